// [hw/mlcs_pkg.sv]
// Package with constants and types for the memory link chip-select timing block
package mlcs_pkg;

    // Field widths
    localparam int CODE_W = 4;        // Idle, set-up, hold and latency codes
    localparam int MAXLEN_W = 9;      // Maximum low time field
    localparam int LAT_W = 5;         // Latency in cycles, 5..16
    localparam int GAP_W = 5;         // Saturating idle-gap counter

    // Select numbering
    localparam logic SEL_FLASH = 1'h0;
    localparam logic SEL_RAM = 1'h1;

    // Target area of the RAM select
    localparam logic AREA_MEM = 1'h0;
    localparam logic AREA_REG = 1'h1;

    // Idle gap: 1.5 cycles at code 0, rounded up to whole cycles
    localparam logic [GAP_W-1:0] GAP_BASE = 5'h02;
    localparam logic [GAP_W-1:0] GAP_SAT = 5'h1F;
    localparam logic [GAP_W-1:0] GAP_RESET = 5'h1F;

    // Set-up and hold: code 0 means one cycle
    localparam logic [CODE_W-1:0] TIME_BASE_M1 = 4'h0;

    // Latency: code 0 is 5 cycles, code 11 is 16 cycles
    localparam logic [LAT_W-1:0] LAT_BASE = 5'h05;
    localparam logic [CODE_W-1:0] LAT_CODE_MAX = 4'hB;
    localparam logic [LAT_W-1:0] LAT_MAX = 5'h10;

    // Reset values of counters
    localparam logic [CODE_W-1:0] CNT_RESET = 4'h0;
    localparam logic [MAXLEN_W-1:0] LOW_RESET = 9'h000;

    // Access sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETUP,
        ST_ACCESS,
        ST_HOLD
    } mlcs_state_e;

endpackage

// [hw/mlcs_gap_timer.sv]
// Counts cycles that one chip select has stayed negated
`timescale 1ns/1ps
`default_nettype none

module mlcs_gap_timer (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Select level as driven on the pin
    input wire logic select_n_i,
    // Completed negated cycles, saturating
    output logic [mlcs_pkg::GAP_W-1:0] gap_o
);

    logic [mlcs_pkg::GAP_W-1:0] gap_reg; // Negated-cycle count

    // Restart on assertion, count while negated, stop at the top
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            gap_reg <= mlcs_pkg::GAP_RESET; // Free to start right after reset
        end else if (!select_n_i) begin
            gap_reg <= '0;
        end else if (gap_reg != mlcs_pkg::GAP_SAT) begin
            gap_reg <= gap_reg + 5'h01;
        end
    end

    assign gap_o = gap_reg;

endmodule
`default_nettype wire

// [hw/mlcs_top.sv]
// Chip-select timing sequencer for a flash select and a RAM select
// Function
// - Select stays negated at least programmed gap
// - Programmed set-up after select assertion
// - Programmed hold before select negation
// - Latency code 0..11 gives 5..16
// - Flash latency reads only; RAM both
// - Optional per-select maximum low time
// - Maximum value N limits to N+1
// - Separate read and write timing sets
// - Two independently configured select spaces
// - RAM select targets memory or registers
`timescale 1ns/1ps
`default_nettype none

module mlcs_top (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RESETN_I,
    // Access request from the read/write path
    input wire logic REQ_I,
    input wire logic REQ_SEL_I,
    input wire logic REQ_WRITE_I,
    output logic REQ_READY_O,
    // Data phase handshake
    output logic ACC_START_O,
    input wire logic ACC_DONE_I,
    output logic [mlcs_pkg::LAT_W-1:0] LAT_CYCLES_O,
    output logic LAT_EN_O,
    output logic RAM_AREA_O,
    output logic MAX_HIT_O,
    output logic BUSY_O,
    // Flash select configuration
    input wire logic [mlcs_pkg::CODE_W-1:0] FLASH_RD_IDLE_I,
    input wire logic [mlcs_pkg::CODE_W-1:0] FLASH_WR_IDLE_I,
    input wire logic [mlcs_pkg::CODE_W-1:0] FLASH_RD_SETUP_I,
    input wire logic [mlcs_pkg::CODE_W-1:0] FLASH_WR_SETUP_I,
    input wire logic [mlcs_pkg::CODE_W-1:0] FLASH_RD_HOLD_I,
    input wire logic [mlcs_pkg::CODE_W-1:0] FLASH_WR_HOLD_I,
    input wire logic [mlcs_pkg::CODE_W-1:0] FLASH_LAT_I,
    input wire logic FLASH_MAX_EN_I,
    input wire logic [mlcs_pkg::MAXLEN_W-1:0] FLASH_MAX_LEN_I,
    // RAM select configuration
    input wire logic [mlcs_pkg::CODE_W-1:0] RAM_RD_IDLE_I,
    input wire logic [mlcs_pkg::CODE_W-1:0] RAM_WR_IDLE_I,
    input wire logic [mlcs_pkg::CODE_W-1:0] RAM_RD_SETUP_I,
    input wire logic [mlcs_pkg::CODE_W-1:0] RAM_WR_SETUP_I,
    input wire logic [mlcs_pkg::CODE_W-1:0] RAM_RD_HOLD_I,
    input wire logic [mlcs_pkg::CODE_W-1:0] RAM_WR_HOLD_I,
    input wire logic [mlcs_pkg::CODE_W-1:0] RAM_LAT_I,
    input wire logic RAM_MAX_EN_I,
    input wire logic [mlcs_pkg::MAXLEN_W-1:0] RAM_MAX_LEN_I,
    input wire logic RAM_AREA_SEL_I,
    // Chip selects, active low
    output logic FLASH_SELECT_N_O,
    output logic RAM_SELECT_N_O
);

    mlcs_pkg::mlcs_state_e state_reg; // Sequencer state
    mlcs_pkg::mlcs_state_e state_next;
    logic sel_reg; // Select of the running access
    logic write_reg; // Direction of the running access
    logic [mlcs_pkg::CODE_W-1:0] cnt_reg; // Set-up and hold down-counter
    logic [mlcs_pkg::CODE_W-1:0] hold_code_reg; // Hold code latched at accept
    logic max_en_reg; // Low-time limit enabled
    logic [mlcs_pkg::MAXLEN_W-1:0] max_len_reg; // Low-time limit value
    logic [mlcs_pkg::MAXLEN_W-1:0] low_reg; // Cycles spent low minus one
    logic flash_sel_n_reg;
    logic ram_sel_n_reg;
    logic start_reg;
    logic hit_reg;
    logic [mlcs_pkg::LAT_W-1:0] lat_reg;
    logic lat_en_reg;
    logic area_reg;
    logic [mlcs_pkg::GAP_W-1:0] flash_gap; // Negated cycles of the flash select
    logic [mlcs_pkg::GAP_W-1:0] ram_gap; // Negated cycles of the RAM select
    logic [mlcs_pkg::CODE_W-1:0] idle_code; // Gap code for the pending request
    logic [mlcs_pkg::CODE_W-1:0] setup_code;
    logic [mlcs_pkg::CODE_W-1:0] hold_code;
    logic [mlcs_pkg::CODE_W-1:0] lat_code;
    logic [mlcs_pkg::GAP_W-1:0] gap_now;
    logic gap_ok; // Requested select has been high long enough
    logic accept; // Request taken this cycle
    logic limit_hit; // Low-time limit reached this cycle

    // One negated-time counter per select
    mlcs_gap_timer u_flash_gap (
        .clk_i(CLK_I),
        .resetn_i(RESETN_I),
        .select_n_i(flash_sel_n_reg),
        .gap_o(flash_gap)
    );
    mlcs_gap_timer u_ram_gap (
        .clk_i(CLK_I),
        .resetn_i(RESETN_I),
        .select_n_i(ram_sel_n_reg),
        .gap_o(ram_gap)
    );

    // Pick the timing set of the requested select and direction
    always_comb begin
        if (REQ_SEL_I == mlcs_pkg::SEL_FLASH) begin
            idle_code = REQ_WRITE_I ? FLASH_WR_IDLE_I : FLASH_RD_IDLE_I;
            setup_code = REQ_WRITE_I ? FLASH_WR_SETUP_I : FLASH_RD_SETUP_I;
            hold_code = REQ_WRITE_I ? FLASH_WR_HOLD_I : FLASH_RD_HOLD_I;
            lat_code = FLASH_LAT_I;
            gap_now = flash_gap;
        end else begin
            idle_code = REQ_WRITE_I ? RAM_WR_IDLE_I : RAM_RD_IDLE_I;
            setup_code = REQ_WRITE_I ? RAM_WR_SETUP_I : RAM_RD_SETUP_I;
            hold_code = REQ_WRITE_I ? RAM_WR_HOLD_I : RAM_RD_HOLD_I;
            lat_code = RAM_LAT_I;
            gap_now = ram_gap;
        end
    end

    // Gap of code+2 cycles: the cycle of assertion ends the gap, hence -1 here
    assign gap_ok = (gap_now >= ({1'h0, idle_code} + mlcs_pkg::GAP_BASE - 5'h01));
    assign REQ_READY_O = (state_reg == mlcs_pkg::ST_IDLE) && gap_ok;
    assign accept = REQ_I && REQ_READY_O;
    // Low time counts from the first low cycle, so value N ends at N+1 cycles
    assign limit_hit = (state_reg != mlcs_pkg::ST_IDLE) && max_en_reg
        && (low_reg == max_len_reg);

    // Next state; the low-time limit overrides every other step
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            mlcs_pkg::ST_IDLE: begin
                if (accept) begin
                    state_next = mlcs_pkg::ST_SETUP;
                end
            end
            mlcs_pkg::ST_SETUP: begin
                if (cnt_reg == mlcs_pkg::TIME_BASE_M1) begin
                    state_next = mlcs_pkg::ST_ACCESS;
                end
            end
            mlcs_pkg::ST_ACCESS: begin
                if (ACC_DONE_I) begin
                    state_next = mlcs_pkg::ST_HOLD;
                end
            end
            mlcs_pkg::ST_HOLD: begin
                if (cnt_reg == mlcs_pkg::TIME_BASE_M1) begin
                    state_next = mlcs_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = mlcs_pkg::ST_IDLE;
            end
        endcase
        if (limit_hit) begin
            state_next = mlcs_pkg::ST_IDLE;
        end
    end

    // State register
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            state_reg <= mlcs_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Latch the access attributes when a request is taken
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            sel_reg <= mlcs_pkg::SEL_FLASH;
            write_reg <= 1'h0;
            hold_code_reg <= mlcs_pkg::CNT_RESET;
            max_en_reg <= 1'h0;
            max_len_reg <= mlcs_pkg::LOW_RESET;
        end else if (accept) begin
            sel_reg <= REQ_SEL_I;
            write_reg <= REQ_WRITE_I;
            hold_code_reg <= hold_code;
            // Each select carries its own limit
            max_en_reg <= (REQ_SEL_I == mlcs_pkg::SEL_RAM) ? RAM_MAX_EN_I
                : FLASH_MAX_EN_I;
            max_len_reg <= (REQ_SEL_I == mlcs_pkg::SEL_RAM) ? RAM_MAX_LEN_I
                : FLASH_MAX_LEN_I;
        end
    end

    // Set-up and hold counter: code N keeps the state N+1 cycles
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            cnt_reg <= mlcs_pkg::CNT_RESET;
        end else if (accept) begin
            cnt_reg <= setup_code;
        end else if (state_reg == mlcs_pkg::ST_ACCESS) begin
            cnt_reg <= hold_code_reg;
        end else if (cnt_reg != mlcs_pkg::CNT_RESET) begin
            cnt_reg <= cnt_reg - 4'h1;
        end
    end

    // Low-time counter, restarted at each assertion
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            low_reg <= mlcs_pkg::LOW_RESET;
        end else if (state_reg == mlcs_pkg::ST_IDLE) begin
            low_reg <= mlcs_pkg::LOW_RESET;
        end else if (low_reg != {mlcs_pkg::MAXLEN_W{1'h1}}) begin
            low_reg <= low_reg + 9'h001;
        end
    end

    // Chip selects follow the next state so they change with it
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            flash_sel_n_reg <= 1'h1;
            ram_sel_n_reg <= 1'h1;
        end else begin
            if (state_reg == mlcs_pkg::ST_IDLE) begin
                flash_sel_n_reg <= !(accept && REQ_SEL_I == mlcs_pkg::SEL_FLASH);
                ram_sel_n_reg <= !(accept && REQ_SEL_I == mlcs_pkg::SEL_RAM);
            end else begin
                flash_sel_n_reg <= (state_next == mlcs_pkg::ST_IDLE)
                    || sel_reg != mlcs_pkg::SEL_FLASH;
                ram_sel_n_reg <= (state_next == mlcs_pkg::ST_IDLE)
                    || sel_reg != mlcs_pkg::SEL_RAM;
            end
        end
    end

    // Data phase start pulse and limit pulse
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            start_reg <= 1'h0;
            hit_reg <= 1'h0;
        end else begin
            start_reg <= (state_reg == mlcs_pkg::ST_SETUP)
                && (state_next == mlcs_pkg::ST_ACCESS);
            hit_reg <= limit_hit;
        end
    end

    // Latency and target area, fixed for the whole access
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            lat_reg <= mlcs_pkg::LAT_BASE;
            lat_en_reg <= 1'h0;
            area_reg <= mlcs_pkg::AREA_MEM;
        end else if (accept) begin
            // Codes above 11 are undefined; clamp to the longest latency
            lat_reg <= (lat_code > mlcs_pkg::LAT_CODE_MAX) ? mlcs_pkg::LAT_MAX
                : ({1'h0, lat_code} + mlcs_pkg::LAT_BASE);
            // Flash writes carry no latency
            lat_en_reg <= (REQ_SEL_I == mlcs_pkg::SEL_RAM) || !REQ_WRITE_I;
            area_reg <= (REQ_SEL_I == mlcs_pkg::SEL_RAM) ? RAM_AREA_SEL_I
                : mlcs_pkg::AREA_MEM;
        end
    end

    assign FLASH_SELECT_N_O = flash_sel_n_reg;
    assign RAM_SELECT_N_O = ram_sel_n_reg;
    assign ACC_START_O = start_reg;
    assign MAX_HIT_O = hit_reg;
    assign LAT_CYCLES_O = lat_reg;
    assign LAT_EN_O = lat_en_reg;
    assign RAM_AREA_O = area_reg;
    assign BUSY_O = (state_reg != mlcs_pkg::ST_IDLE);

    // Helper: direction of the running access, read by assertions only
    logic dir_w;
    assign dir_w = write_reg;

    a_one_select: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        !(!FLASH_SELECT_N_O && !RAM_SELECT_N_O))
        else $error("both selects asserted");
    // Count compared as it stands, so a saturated counter cannot wrap to zero
    a_gap_flash: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        $fell(FLASH_SELECT_N_O) |-> $past(flash_gap) >= 5'h01)
        else $error("flash gap shorter than minimum");
    a_gap_ram: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        $fell(RAM_SELECT_N_O) |-> $past(ram_gap) >= 5'h01)
        else $error("ram gap shorter than minimum");
    a_setup_min: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        accept && setup_code == 4'h0 ##1 !limit_hit |=> ACC_START_O)
        else $error("one-cycle set-up not honoured");
    a_setup_long: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        accept && setup_code == 4'h2 |=> !ACC_START_O [*3])
        else $error("set-up ended early");
    a_hold_len: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        state_reg == mlcs_pkg::ST_ACCESS && ACC_DONE_I && hold_code_reg == 4'h1
        && !limit_hit ##1 !limit_hit ##1 !limit_hit |-> BUSY_O ##1 !BUSY_O)
        else $error("hold length wrong");
    a_lat_range: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        LAT_CYCLES_O >= 5'h05 && LAT_CYCLES_O <= 5'h10)
        else $error("latency out of range");
    a_lat_flash_wr: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        BUSY_O && sel_reg == mlcs_pkg::SEL_FLASH |-> LAT_EN_O == !dir_w)
        else $error("flash latency applied to write");
    a_lat_ram: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        BUSY_O && sel_reg == mlcs_pkg::SEL_RAM |-> LAT_EN_O)
        else $error("ram latency missing");
    a_max_low: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        limit_hit |=> FLASH_SELECT_N_O && RAM_SELECT_N_O && MAX_HIT_O)
        else $error("limit did not negate select");
    a_max_zero: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        accept && REQ_SEL_I && RAM_MAX_EN_I && RAM_MAX_LEN_I == 9'h000
        |=> !RAM_SELECT_N_O ##1 RAM_SELECT_N_O)
        else $error("limit zero not one cycle");
    a_area_flash: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        $rose(BUSY_O) && sel_reg == mlcs_pkg::SEL_FLASH |-> RAM_AREA_O == 1'h0)
        else $error("flash access tagged register area");

    c_flash_read: cover property (@(posedge CLK_I) disable iff (!RESETN_I)
        accept && !REQ_SEL_I && !REQ_WRITE_I ##[1:40] ACC_START_O);
    c_ram_write: cover property (@(posedge CLK_I) disable iff (!RESETN_I)
        accept && REQ_SEL_I && REQ_WRITE_I ##[1:40] ACC_START_O);
    c_limit: cover property (@(posedge CLK_I) disable iff (!RESETN_I) MAX_HIT_O);

endmodule
`default_nettype wire

// [verif/mlcs_mem_model.sv]
// Data-phase model of the memory devices behind both chip selects
`timescale 1ns/1ps
`default_nettype none

module mlcs_mem_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Controller side
    input wire logic start_i,
    input wire logic flash_select_n_i,
    input wire logic ram_select_n_i,
    // Cycles from data-phase start to completion
    input wire logic [15:0] delay_i,
    // Completion pulse
    output logic done_o
);
    logic [15:0] cnt; // Cycles spent in the data phase
    logic active; // Data phase under way
    logic fire; // Completion decided this edge

    // Count from the start pulse, answer on the falling edge, one write per edge
    always @(negedge clk_i) begin
        fire = 1'b0;
        // A cut access must not leave a stale completion behind
        if (!resetn_i || (flash_select_n_i && ram_select_n_i)) begin
            active = 1'b0;
        end else if (start_i) begin
            active = 1'b1;
            cnt = 16'h0000;
        end
        if (active) begin
            if (cnt == delay_i) begin
                fire = 1'b1;
                active = 1'b0;
            end else begin
                cnt = cnt + 16'h0001;
            end
        end
        done_o <= fire;
    end

    // Quiet at time zero
    initial begin
        done_o = 1'b0;
        active = 1'b0;
        fire = 1'b0;
        cnt = 16'h0000;
    end
endmodule
`default_nettype wire

// [verif/tb_mlcs_top.sv]
// Self-checking bench for the chip-select timing sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_mlcs_top;
    // Clock, reset, request and handshake
    logic CLK_I, RESETN_I, REQ_I, REQ_SEL_I, REQ_WRITE_I, ACC_DONE_I;
    logic REQ_READY_O, ACC_START_O, LAT_EN_O, RAM_AREA_O, MAX_HIT_O, BUSY_O;
    logic FLASH_SELECT_N_O, RAM_SELECT_N_O;
    logic [mlcs_pkg::LAT_W-1:0] LAT_CYCLES_O;
    // Timing codes indexed {select, write}
    logic [mlcs_pkg::CODE_W-1:0] su [4], ho [4], idl [4];
    logic [mlcs_pkg::CODE_W-1:0] FLASH_LAT_I, RAM_LAT_I;
    logic FLASH_MAX_EN_I, RAM_MAX_EN_I, RAM_AREA_SEL_I;
    logic [mlcs_pkg::MAXLEN_W-1:0] FLASH_MAX_LEN_I, RAM_MAX_LEN_I;
    // Results of the last access
    logic [15:0] lows, st, wd, lat, en, area, hit, dly, bsy;
    int err_total, samples_checked;

    mlcs_top i_mlcs_top (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .REQ_I(REQ_I),
        .REQ_SEL_I(REQ_SEL_I), .REQ_WRITE_I(REQ_WRITE_I), .REQ_READY_O(REQ_READY_O),
        .ACC_START_O(ACC_START_O), .ACC_DONE_I(ACC_DONE_I), .LAT_CYCLES_O(LAT_CYCLES_O),
        .LAT_EN_O(LAT_EN_O), .RAM_AREA_O(RAM_AREA_O), .MAX_HIT_O(MAX_HIT_O), .BUSY_O(BUSY_O),
        .FLASH_RD_IDLE_I(idl[0]), .FLASH_WR_IDLE_I(idl[1]), .FLASH_RD_SETUP_I(su[0]),
        .FLASH_WR_SETUP_I(su[1]), .FLASH_RD_HOLD_I(ho[0]), .FLASH_WR_HOLD_I(ho[1]),
        .FLASH_LAT_I(FLASH_LAT_I), .FLASH_MAX_EN_I(FLASH_MAX_EN_I),
        .FLASH_MAX_LEN_I(FLASH_MAX_LEN_I), .RAM_RD_IDLE_I(idl[2]), .RAM_WR_IDLE_I(idl[3]),
        .RAM_RD_SETUP_I(su[2]), .RAM_WR_SETUP_I(su[3]), .RAM_RD_HOLD_I(ho[2]),
        .RAM_WR_HOLD_I(ho[3]), .RAM_LAT_I(RAM_LAT_I), .RAM_MAX_EN_I(RAM_MAX_EN_I),
        .RAM_MAX_LEN_I(RAM_MAX_LEN_I), .RAM_AREA_SEL_I(RAM_AREA_SEL_I),
        .FLASH_SELECT_N_O(FLASH_SELECT_N_O), .RAM_SELECT_N_O(RAM_SELECT_N_O));

    mlcs_mem_model i_mlcs_mem_model (.clk_i(CLK_I), .resetn_i(RESETN_I),
        .start_i(ACC_START_O), .flash_select_n_i(FLASH_SELECT_N_O),
        .ram_select_n_i(RAM_SELECT_N_O), .delay_i(dly), .done_o(ACC_DONE_I));

    // 20 MHz clock
    initial begin
        CLK_I = 1'b0;
        forever #25 CLK_I = ~CLK_I;
    end

    // Compare and count
    task automatic chk(input string nm, input logic [15:0] seen, input int exp);
        samples_checked++;
        if (seen !== exp[15:0]) begin
            err_total++;
            $display("ERROR %s expected %0d seen %0d", nm, exp, seen);
        end
    endtask

    // Counts, verdict, end of run
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // One access: request held until taken, then the low period is measured
    task automatic acc(input logic s, input logic w, input int d);
        lows = 16'h0000;
        st = 16'h0000;
        wd = 16'h0000;
        REQ_SEL_I = s;
        REQ_WRITE_I = w;
        dly = 16'(d);
        REQ_I = 1'b1;
        #1;
        // Wait counted in cycles; bounded so a refusal cannot hang
        while (REQ_READY_O !== 1'b1 && wd < 16'h00C8) begin
            @(negedge CLK_I);
            #1;
            wd++;
        end
        @(negedge CLK_I);
        #1;
        REQ_I = 1'b0;
        lat = 16'(LAT_CYCLES_O);
        en = 16'(LAT_EN_O);
        area = 16'(RAM_AREA_O);
        bsy = 16'(BUSY_O);
        while ((s ? RAM_SELECT_N_O : FLASH_SELECT_N_O) === 1'b0 && lows < 16'h0400) begin
            lows++;
            if (ACC_START_O === 1'b1) begin
                st = lows;
            end
            @(negedge CLK_I);
            #1;
        end
        hit = 16'(MAX_HIT_O);
        // Busy in the first low cycle, idle in the first high cycle
        bsy = 16'({bsy[0], BUSY_O});
    endtask

    // Limited access on one select
    task automatic lim(input logic s, input logic w, input int n, input int d, input int el);
        FLASH_MAX_LEN_I = n[8:0];
        RAM_MAX_LEN_I = n[8:0];
        acc(s, w, d);
        chk("max_lows", lows, el);
        chk("max_hit", hit, (el == n + 1) ? 1 : 0);
    endtask

    // Watchdog well beyond the few thousand cycles of the run
    initial begin
        #1000000;
        err_total++;
        give_verdict();
    end

    // Main sequence
    initial begin
        err_total = 0;
        samples_checked = 0;
        RESETN_I = 1'b0;
        REQ_I = 1'b0;
        REQ_SEL_I = 1'b0;
        REQ_WRITE_I = 1'b0;
        dly = 16'h0000;
        // Distinct sets per select and direction
        su = '{4'h0, 4'h3, 4'hF, 4'h2};
        ho = '{4'h0, 4'h1, 4'hF, 4'h5};
        idl = '{4'h0, 4'h0, 4'h0, 4'h0};
        FLASH_LAT_I = 4'h0;
        RAM_LAT_I = 4'h0;
        FLASH_MAX_EN_I = 1'b0;
        RAM_MAX_EN_I = 1'b0;
        FLASH_MAX_LEN_I = 9'h000;
        RAM_MAX_LEN_I = 9'h000;
        RAM_AREA_SEL_I = 1'b0;
        repeat (5) @(negedge CLK_I);
        RESETN_I = 1'b1;
        #1;
        chk("reset_selects", 16'({FLASH_SELECT_N_O, RAM_SELECT_N_O}), 3);
        chk("reset_flags", 16'({REQ_READY_O, BUSY_O, MAX_HIT_O, ACC_START_O}), 8);
        chk("reset_lat", 16'(LAT_CYCLES_O), 5);
        // Every latency code on all four select and direction pairs
        for (int c = 0; c < 16; c++) begin
            FLASH_LAT_I = c[3:0];
            RAM_LAT_I = c[3:0];
            RAM_AREA_SEL_I = c[0];
            for (int k = 0; k < 4; k++) begin
                acc(k[1], k[0], c % 3);
                chk("start", st, su[k] + 2);
                chk("lows", lows, su[k] + ho[k] + c % 3 + 3);
                chk("latency", lat, (c > 11) ? 16 : c + 5);
                chk("lat_en", en, (k == 1) ? 0 : 1);
                chk("area", area, k[1] & c[0]);
                chk("no_limit", hit, 0);
                chk("busy", bsy, 2);
            end
        end
        // Back-to-back idle gaps, read and write sets, other select free
        for (int c = 0; c < 16; c += 5) begin
            idl[0] = c[3:0];
            idl[1] = 4'hF - c[3:0];
            idl[3] = c[3:0];
            acc(1'b0, 1'b0, 0);
            acc(1'b0, 1'b0, 0);
            chk("gap_rd", wd, c + 1);
            acc(1'b0, 1'b1, 0);
            chk("gap_wr", wd, 16 - c);
            acc(1'b1, 1'b1, 0);
            chk("other_free", wd, 0);
            acc(1'b1, 1'b1, 0);
            chk("gap_ram", wd, c + 1);
        end
        // Low-time limit at its bounds, then a short access under a wide limit
        FLASH_MAX_EN_I = 1'b1;
        RAM_MAX_EN_I = 1'b1;
        lim(1'b0, 1'b0, 0, 50, 1);
        lim(1'b0, 1'b1, 3, 50, 4);
        lim(1'b1, 1'b0, 0, 50, 1);
        lim(1'b1, 1'b0, 511, 600, 512);
        lim(1'b1, 1'b1, 511, 2, 12);
        give_verdict();
    end
endmodule
`default_nettype wire
